// >>> verilog/tic_pkg.sv
// Constants for the timer input capture and compare-output pin unit.
// Assumes a 32-bit AXI4-Lite register bus and one clock, MCLK.
`default_nettype none

package tic_pkg;

   // ***************************************************
   // Register byte addresses
   // ***************************************************
   localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h08;
   localparam logic [7:0] ADDR_FLAG     = 8'h0c;
   localparam logic [7:0] ADDR_CAP_LOW  = 8'h10;
   localparam logic [7:0] ADDR_CAP_HIGH = 8'h14;
   localparam logic [7:0] ADDR_COMP     = 8'h18;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int COM_A_LSB     = 6;
   localparam int COM_B_LSB     = 4;
   localparam int WGM_LO_LSB    = 0;
   localparam int WGM_HI_LSB    = 3;
   localparam int EDGE_RISE_BIT = 6;
   localparam int IRQ_EN_BIT    = 0;
   localparam int FLAG_BIT      = 0;
   localparam int COMP_SEL_BIT  = 2;
   localparam int COMP_OUT_BIT  = 5;

   // ***************************************************
   // Reset values, responses and synchroniser depth
   // ***************************************************
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [3:0] WGM_RST    = 4'h0;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLV   = 2'h2;
   localparam int         SYNC_STAGES = 2;

endpackage

`default_nettype wire

// >>> verilog/tic_sync.sv
// Two-stage level synchroniser for one asynchronous input.
// Assumes the input may change at any time relative to the clock.
`default_nettype none

module tic_sync
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Level
   input  wire logic d_async,
   output var  logic q_sync
);

   logic meta_r;
   logic meta_nxt;
   logic q_nxt;

   always_comb
   begin
      meta_nxt = d_async;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_r <= 1'b0;
         q_sync <= 1'b0;
      end
      else
      begin
         meta_r <= meta_nxt;
         q_sync <= q_nxt;
      end
   end

endmodule

`default_nettype wire

// >>> verilog/tic_top.sv
// Input capture unit with 8-bit register access and compare pin override.
// Assumes TIMER_COUNT and OC_x_WAVE come from the timer on MCLK;
// capture pin and comparator output are asynchronous.
`default_nettype none

module tic_top
(
   // Clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST,
   // AXI4-Lite write
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output var  logic        S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output var  logic        S_AXI_WREADY,
   output var  logic [1:0]  S_AXI_BRESP,
   output var  logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   // AXI4-Lite read
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output var  logic        S_AXI_ARREADY,
   output var  logic [31:0] S_AXI_RDATA,
   output var  logic [1:0]  S_AXI_RRESP,
   output var  logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Timer side
   input  wire logic [15:0] TIMER_COUNT,
   input  wire logic        OC_A_WAVE,
   input  wire logic        OC_B_WAVE,
   output var  logic [3:0]  WAVEFORM_MODE,
   output var  logic [1:0]  COM_MODE_A,
   output var  logic [1:0]  COM_MODE_B,
   output var  logic [15:0] CAPTURE_TOP,
   // Capture sources
   input  wire logic        CAPTURE_PIN,
   input  wire logic        COMPARATOR_OUT,
   // Interrupt request and acknowledge
   output var  logic        CAPTURE_IRQ,
   input  wire logic        CAPTURE_IRQ_ACK,
   // Port pins A and B
   input  wire logic        PORT_A_OUT,
   input  wire logic        PORT_A_DDR,
   input  wire logic        PORT_B_OUT,
   input  wire logic        PORT_B_DDR,
   output var  logic        PIN_A_OUT,
   output var  logic        PIN_A_OE,
   output var  logic        PIN_B_OUT,
   output var  logic        PIN_B_OE
);

   // ***************************************************
   // State
   // ***************************************************
   logic        aw_v_r, aw_v_nxt, w_v_r, w_v_nxt;
   logic [7:0]  awaddr_r, awaddr_nxt;
   logic [7:0]  wdata_r, wdata_nxt;
   logic        wstb_r, wstb_nxt;
   logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [7:0]  rdata_r, rdata_nxt;
   logic [7:0]  ctrl_a_r, ctrl_a_nxt;
   logic [3:0]  wgm_r, wgm_nxt;
   logic        rise_r, rise_nxt, irq_en_r, irq_en_nxt;
   logic        comp_sel_r, comp_sel_nxt;
   logic        flag_r, flag_nxt;
   logic [15:0] cap_r, cap_nxt;
   logic [7:0]  temp_r, temp_nxt;
   logic        prev_r, prev_nxt, arm_r, arm_nxt;
   logic        pa_out_r, pa_out_nxt, pa_oe_r, pa_oe_nxt;
   logic        pb_out_r, pb_out_nxt, pb_oe_r, pb_oe_nxt;

   logic        pin_s, comp_s, src, edge_hit, cap_go, icr_top;
   logic        wr_go, rd_go, wr_ok, clr_w1c;

   // ***************************************************
   // Trigger source synchronisers
   // ***************************************************
   tic_sync u_sync_pin
   (
      .clk     (MCLK),
      .rst     (RST),
      .d_async (CAPTURE_PIN),
      .q_sync  (pin_s)
   );

   tic_sync u_sync_comp
   (
      .clk     (MCLK),
      .rst     (RST),
      .d_async (COMPARATOR_OUT),
      .q_sync  (comp_s)
   );

   // ***************************************************
   // Next-state logic
   // ***************************************************
   always_comb
   begin
      icr_top  = wgm_r[3] & ~wgm_r[0];
      src      = comp_sel_r ? comp_s : pin_s;
      edge_hit = arm_r & (rise_r ? (src & ~prev_r)
                                 : (~src & prev_r));
      cap_go   = edge_hit & ~icr_top;
      wr_go    = aw_v_r & w_v_r & ~bvalid_r;
      rd_go    = S_AXI_ARVALID & ~rvalid_r;
      wr_ok    = wstb_r;
      clr_w1c  = wr_go & wr_ok & (awaddr_r == tic_pkg::ADDR_FLAG)
                 & wdata_r[tic_pkg::FLAG_BIT];

      aw_v_nxt     = aw_v_r;
      awaddr_nxt   = awaddr_r;
      w_v_nxt      = w_v_r;
      wdata_nxt    = wdata_r;
      wstb_nxt     = wstb_r;
      bvalid_nxt   = bvalid_r;
      bresp_nxt    = bresp_r;
      rvalid_nxt   = rvalid_r;
      rresp_nxt    = rresp_r;
      rdata_nxt    = rdata_r;
      ctrl_a_nxt   = ctrl_a_r;
      wgm_nxt      = wgm_r;
      rise_nxt     = rise_r;
      irq_en_nxt   = irq_en_r;
      comp_sel_nxt = comp_sel_r;
      cap_nxt      = cap_r;
      temp_nxt     = temp_r;
      prev_nxt     = src;
      arm_nxt      = 1'b1;

      // Address and data held until both present
      if (S_AXI_AWVALID & ~aw_v_r)
      begin
         aw_v_nxt   = 1'b1;
         awaddr_nxt = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & ~w_v_r)
      begin
         w_v_nxt   = 1'b1;
         wdata_nxt = S_AXI_WDATA[7:0];
         wstb_nxt  = S_AXI_WSTRB[0];
      end
      if (S_AXI_BVALID & S_AXI_BREADY)
      begin
         bvalid_nxt = 1'b0;
      end
      if (S_AXI_RVALID & S_AXI_RREADY)
      begin
         rvalid_nxt = 1'b0;
      end

      // Read path
      if (rd_go)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = tic_pkg::RESP_OKAY;
         rdata_nxt  = 8'h00;
         unique case (S_AXI_ARADDR)
            tic_pkg::ADDR_CTRL_A:
               rdata_nxt = {ctrl_a_r[7:2], wgm_r[1:0]};
            tic_pkg::ADDR_CTRL_B:
               rdata_nxt = {1'b0, rise_r, 1'b0, wgm_r[3:2], 3'h0};
            tic_pkg::ADDR_IRQ_EN:
               rdata_nxt = {7'h00, irq_en_r};
            tic_pkg::ADDR_FLAG:
               rdata_nxt = {7'h00, flag_r};
            tic_pkg::ADDR_CAP_LOW:
            begin
               rdata_nxt = cap_r[7:0];
               temp_nxt  = cap_r[15:8];
            end
            tic_pkg::ADDR_CAP_HIGH:
               rdata_nxt = temp_r;
            tic_pkg::ADDR_COMP:
            begin
               rdata_nxt[tic_pkg::COMP_OUT_BIT] = comp_s;
               rdata_nxt[tic_pkg::COMP_SEL_BIT] = comp_sel_r;
            end
            default:
               rresp_nxt = tic_pkg::RESP_SLV;
         endcase
      end

      // Write path
      if (wr_go)
      begin
         aw_v_nxt   = 1'b0;
         w_v_nxt    = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = tic_pkg::RESP_OKAY;
         unique case (awaddr_r)
            tic_pkg::ADDR_CTRL_A:
            begin
               if (wr_ok)
               begin
                  ctrl_a_nxt   = wdata_r;
                  wgm_nxt[1:0] = wdata_r[tic_pkg::WGM_LO_LSB +: 2];
               end
            end
            tic_pkg::ADDR_CTRL_B:
            begin
               if (wr_ok)
               begin
                  rise_nxt     = wdata_r[tic_pkg::EDGE_RISE_BIT];
                  wgm_nxt[3:2] = wdata_r[tic_pkg::WGM_HI_LSB +: 2];
               end
            end
            tic_pkg::ADDR_IRQ_EN:
            begin
               if (wr_ok)
               begin
                  irq_en_nxt = wdata_r[tic_pkg::IRQ_EN_BIT];
               end
            end
            tic_pkg::ADDR_FLAG:
               ;
            tic_pkg::ADDR_CAP_HIGH:
            begin
               if (wr_ok)
               begin
                  temp_nxt = wdata_r;
               end
            end
            tic_pkg::ADDR_CAP_LOW:
            begin
               if (wr_ok & icr_top)
               begin
                  cap_nxt = {temp_r, wdata_r};
               end
            end
            tic_pkg::ADDR_COMP:
            begin
               if (wr_ok)
               begin
                  comp_sel_nxt = wdata_r[tic_pkg::COMP_SEL_BIT];
               end
            end
            default:
               bresp_nxt = tic_pkg::RESP_SLV;
         endcase
      end

      // Capture wins over a write to the capture register
      if (cap_go)
      begin
         cap_nxt = TIMER_COUNT;
      end

      // Flag: set beats clear
      flag_nxt = flag_r;
      if (clr_w1c | CAPTURE_IRQ_ACK)
      begin
         flag_nxt = 1'b0;
      end
      if (cap_go)
      begin
         flag_nxt = 1'b1;
      end

      // Pin override
      pa_out_nxt = PORT_A_OUT;
      pb_out_nxt = PORT_B_OUT;
      if (ctrl_a_r[tic_pkg::COM_A_LSB +: 2] != 2'h0)
      begin
         pa_out_nxt = OC_A_WAVE;
      end
      if (ctrl_a_r[tic_pkg::COM_B_LSB +: 2] != 2'h0)
      begin
         pb_out_nxt = OC_B_WAVE;
      end
      pa_oe_nxt = PORT_A_DDR;
      pb_oe_nxt = PORT_B_DDR;
   end

   // ***************************************************
   // Registers
   // ***************************************************
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         aw_v_r <= 1'b0;  awaddr_r <= 8'h00;
         w_v_r  <= 1'b0;  wdata_r  <= 8'h00;  wstb_r <= 1'b0;
         bvalid_r <= 1'b0;  bresp_r <= tic_pkg::RESP_OKAY;
         rvalid_r <= 1'b0;  rresp_r <= tic_pkg::RESP_OKAY;
         rdata_r  <= 8'h00;
         ctrl_a_r <= tic_pkg::CTRL_A_RST;
         wgm_r    <= tic_pkg::WGM_RST;
         rise_r   <= 1'b0;  irq_en_r <= 1'b0;  comp_sel_r <= 1'b0;
         flag_r   <= 1'b0;  cap_r    <= 16'h0000;  temp_r <= 8'h00;
         prev_r   <= 1'b0;  arm_r    <= 1'b0;
         pa_out_r <= 1'b0;  pa_oe_r  <= 1'b0;
         pb_out_r <= 1'b0;  pb_oe_r  <= 1'b0;
      end
      else
      begin
         aw_v_r <= aw_v_nxt;  awaddr_r <= awaddr_nxt;
         w_v_r  <= w_v_nxt;   wdata_r  <= wdata_nxt;  wstb_r <= wstb_nxt;
         bvalid_r <= bvalid_nxt;  bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;  rresp_r <= rresp_nxt;
         rdata_r  <= rdata_nxt;
         ctrl_a_r <= ctrl_a_nxt;  wgm_r <= wgm_nxt;
         rise_r   <= rise_nxt;  irq_en_r <= irq_en_nxt;
         comp_sel_r <= comp_sel_nxt;
         flag_r   <= flag_nxt;  cap_r <= cap_nxt;  temp_r <= temp_nxt;
         prev_r   <= prev_nxt;  arm_r <= arm_nxt;
         pa_out_r <= pa_out_nxt;  pa_oe_r <= pa_oe_nxt;
         pb_out_r <= pb_out_nxt;  pb_oe_r <= pb_oe_nxt;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign S_AXI_AWREADY = ~aw_v_r;
   assign S_AXI_WREADY  = ~w_v_r;
   assign S_AXI_BVALID  = bvalid_r;
   assign S_AXI_BRESP   = bresp_r;
   assign S_AXI_ARREADY = ~rvalid_r;
   assign S_AXI_RVALID  = rvalid_r;
   assign S_AXI_RRESP   = rresp_r;
   assign S_AXI_RDATA   = {24'h000000, rdata_r};
   assign CAPTURE_IRQ   = flag_r & irq_en_r;
   assign WAVEFORM_MODE = wgm_r;
   assign COM_MODE_A    = ctrl_a_r[tic_pkg::COM_A_LSB +: 2];
   assign COM_MODE_B    = ctrl_a_r[tic_pkg::COM_B_LSB +: 2];
   assign CAPTURE_TOP   = cap_r;
   assign PIN_A_OUT     = pa_out_r;
   assign PIN_A_OE      = pa_oe_r;
   assign PIN_B_OUT     = pb_out_r;
   assign PIN_B_OE      = pb_oe_r;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   sequence s_rise_seen;
      arm_r && rise_r && !prev_r ##0 src && !icr_top;
   endsequence
   sequence s_low_read;
      rd_go && S_AXI_ARADDR == tic_pkg::ADDR_CAP_LOW
         && !(wr_go && wr_ok && awaddr_r == tic_pkg::ADDR_CAP_HIGH);
   endsequence
   sequence s_high_read;
      rd_go && S_AXI_ARADDR == tic_pkg::ADDR_CAP_HIGH;
   endsequence

   property p_trigger;
      s_rise_seen |=> flag_r;
   endproperty
   a_trigger: assert property (p_trigger)
      else $error("rising edge did not capture");

   property p_copy;
      cap_go |=> cap_r == $past(TIMER_COUNT);
   endproperty
   a_copy: assert property (p_copy)
      else $error("capture value differs from count");

   property p_same_clk;
      $rose(flag_r) |-> $past(cap_go) && cap_r == $past(TIMER_COUNT);
   endproperty
   a_same_clk: assert property (p_same_clk)
      else $error("flag and capture not in same cycle");

   property p_irq;
      cap_go ##1 irq_en_r |-> CAPTURE_IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not requested");

   property p_ack;
      CAPTURE_IRQ_ACK && !cap_go |=> !flag_r;
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledge did not clear flag");

   property p_w1c;
      clr_w1c && !cap_go |=> !flag_r;
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("write one did not clear flag");

   property p_shadow;
      s_low_read |=> temp_r == $past(cap_r[15:8]);
   endproperty
   a_shadow: assert property (p_shadow)
      else $error("low read did not load shadow");

   property p_shadow_rd;
      s_high_read |=> rdata_r == $past(temp_r);
   endproperty
   a_shadow_rd: assert property (p_shadow_rd)
      else $error("high read not from shadow");

   property p_lock;
      wr_go && awaddr_r == tic_pkg::ADDR_CAP_LOW && !icr_top && !cap_go
         |=> $stable(cap_r);
   endproperty
   a_lock: assert property (p_lock)
      else $error("capture register written outside TOP mode");

   property p_override_a;
      COM_MODE_A != 2'h0 |=> PIN_A_OUT == $past(OC_A_WAVE);
   endproperty
   a_override_a: assert property (p_override_a)
      else $error("channel A did not override pin");

   property p_override_b;
      COM_MODE_B != 2'h0 |=> PIN_B_OUT == $past(OC_B_WAVE);
   endproperty
   a_override_b: assert property (p_override_b)
      else $error("channel B did not override pin");

   property p_dir;
      !PORT_A_DDR ##1 !PORT_A_DDR |-> !PIN_A_OE;
   endproperty
   a_dir: assert property (p_dir)
      else $error("pin A driven without direction bit");

endmodule

`default_nettype wire

// >>> verification/tic_src.sv
// Far-side model: the capture pin and the comparator output levels.
// Assumes the bench calls drive; levels change just after MCLK edges.
`default_nettype none

module tic_src
(
   // Clock
   input  wire logic clk,
   // Capture sources
   output var  logic cap_pin,
   output var  logic comp_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      cap_pin  = 1'b0;
      comp_out = 1'b0;
   end

   // Set one source level, then hold it for gap cycles
   task automatic drive(input logic sel, input logic v, input int gap);
      @(posedge clk);
      if (sel)
         comp_out <= v;
      else
         cap_pin <= v;
      repeat (gap) @(posedge clk);
   endtask
endmodule

`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the capture unit over AXI4-Lite.
// Assumes tic_pkg and tic_top compiled first; tic_src drives sources.
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************
   // Signals
   // ***************************************************
   logic        clk = 1'b0, rst = 1'b1;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0, ack = 0, oca = 0, ocb = 0;
   logic        pao = 0, pad = 0, pbo = 0, pbd = 0;
   logic [15:0] cnt = 16'h0, ctop, t1, t2;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp, coma, comb, r;
   logic [3:0]  wmode;
   logic        pina, pinaoe, pinb, pinboe, cpin, comp, ackm = 0;
   logic [7:0]  h, l;
   logic [31:0] d;
   int          n_errors = 0, checked = 0;

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   tic_src src (.clk(clk), .cap_pin(cpin), .comp_out(comp));

   tic_top dut
   (
      .MCLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .TIMER_COUNT(cnt), .OC_A_WAVE(oca),
      .OC_B_WAVE(ocb), .WAVEFORM_MODE(wmode), .COM_MODE_A(coma),
      .COM_MODE_B(comb), .CAPTURE_TOP(ctop), .CAPTURE_PIN(cpin),
      .COMPARATOR_OUT(comp), .CAPTURE_IRQ(irq), .CAPTURE_IRQ_ACK(ack),
      .PORT_A_OUT(pao), .PORT_A_DDR(pad), .PORT_B_OUT(pbo),
      .PORT_B_DDR(pbd), .PIN_A_OUT(pina), .PIN_A_OE(pinaoe),
      .PIN_B_OUT(pinb), .PIN_B_OE(pinboe)
   );

   // ***************************************************
   // Checks and bus tasks
   // ***************************************************
   function automatic logic exp_pin(logic [1:0] c, logic w, logic p);
      return (c != 2'h0) ? w : p;
   endfunction

   task automatic chk(input logic [15:0] g, input logic [15:0] e,
                      input string m);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int k = 0;
      bit ad = 0, wd = 0;
      @(posedge clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= {24'h0, v};
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
         if (!ad && awready)
            awvalid <= 1'b0;
         if (!wd && wready)
            wvalid <= 1'b0;
         ad = ad | awready;
         wd = wd | wready;
      end
      while (!bvalid && k < 100);
      r = bresp;
      bready <= 1'b0;
      chk(16'(bvalid), 16'h1, "write stuck");
   endtask

   task automatic rd(input logic [7:0] a);
      int k = 0;
      bit ad = 0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
         if (!ad && arready)
            arvalid <= 1'b0;
         ad = ad | arready;
      end
      while (!rvalid && k < 100);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      chk(16'(rvalid), 16'h1, "read stuck");
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] e,
                      input string m);
      rd(a);
      chk(d[15:0], e, m);
   endtask

   // Source edge with a fresh count; hit says whether it captures
   task automatic cap_step(input logic sel, input logic v, input logic hit);
      logic [15:0] t;
      t = 16'($urandom);
      cnt <= t;
      src.drive(sel, v, 6);
      chk(16'(irq), 16'(hit), "irq");
      rdc(tic_pkg::ADDR_FLAG, 16'(hit), "flag");
      if (hit)
      begin
         rdc(tic_pkg::ADDR_CAP_LOW, 16'(t[7:0]), "low");
         rdc(tic_pkg::ADDR_CAP_HIGH, 16'(t[15:8]), "high");
         ackm = ~ackm;
         if (ackm)
         begin
            @(posedge clk);
            ack <= 1'b1;
            @(posedge clk);
            ack <= 1'b0;
         end
         else
            wr(tic_pkg::ADDR_FLAG, 8'h01);
         rdc(tic_pkg::ADDR_FLAG, 16'h0, "flag clear");
      end
   endtask

   task automatic print_verdict();
      $display("Errors %0d, checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ***************************************************
   // Tests
   // ***************************************************
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end

   initial
   begin
      t1 = 16'($urandom(72));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(8'h1c);
      chk(16'(r), 16'(tic_pkg::RESP_SLV), "unmapped read");
      wr(8'h1c, 8'hff);
      chk(16'(r), 16'(tic_pkg::RESP_SLV), "unmapped write");
      rdc(tic_pkg::ADDR_CTRL_A, 16'(tic_pkg::CTRL_A_RST), "ctrl a");
      wr(tic_pkg::ADDR_IRQ_EN, 8'h01);
      for (int i = 0; i < 6; i++)
      begin
         wr(tic_pkg::ADDR_CTRL_B, i[0] ? 8'h40 : 8'h00);
         cap_step(1'b0, 1'b1, i[0]);
         cap_step(1'b0, 1'b0, !i[0]);
      end
      t1 = 16'($urandom);
      t2 = t1 ^ 16'h5a5a;
      cnt <= t1;
      src.drive(1'b0, 1'b1, 6);
      rdc(tic_pkg::ADDR_CAP_LOW, 16'(t1[7:0]), "low 1");
      cnt <= t2;
      src.drive(1'b0, 1'b0, 2);
      src.drive(1'b0, 1'b1, 6);
      rdc(tic_pkg::ADDR_CAP_HIGH, 16'(t1[15:8]), "shadow");
      rdc(tic_pkg::ADDR_CAP_LOW, 16'(t2[7:0]), "low 2");
      rdc(tic_pkg::ADDR_CAP_HIGH, 16'(t2[15:8]), "high 2");
      wr(tic_pkg::ADDR_FLAG, 8'h01);
      src.drive(1'b0, 1'b0, 6);
      wr(tic_pkg::ADDR_COMP, 8'h04);
      wr(tic_pkg::ADDR_FLAG, 8'h01);
      cap_step(1'b0, 1'b1, 1'b0);
      cap_step(1'b1, 1'b1, 1'b1);
      rdc(tic_pkg::ADDR_COMP, 16'h0024, "comp level");
      cap_step(1'b0, 1'b0, 1'b0);
      cap_step(1'b1, 1'b0, 1'b0);
      wr(tic_pkg::ADDR_COMP, 8'h00);
      wr(tic_pkg::ADDR_FLAG, 8'h01);
      wr(tic_pkg::ADDR_CTRL_B, 8'h58);
      chk(16'(wmode), 16'h000c, "mode");
      h = 8'($urandom);
      l = 8'($urandom);
      wr(tic_pkg::ADDR_CAP_HIGH, h);
      wr(tic_pkg::ADDR_CAP_LOW, l);
      chk(ctop, {h, l}, "top");
      wr(tic_pkg::ADDR_CAP_LOW, ~l);
      chk(ctop, {h, ~l}, "top reuse");
      cap_step(1'b0, 1'b1, 1'b0);
      cap_step(1'b0, 1'b0, 1'b0);
      wr(tic_pkg::ADDR_CTRL_B, 8'h40);
      wr(tic_pkg::ADDR_CAP_HIGH, ~h);
      wr(tic_pkg::ADDR_CAP_LOW, l);
      chk(ctop, {h, ~l}, "top locked");
      for (int c = 0; c < 4; c++)
      begin
         wr(tic_pkg::ADDR_CTRL_A, {c[1:0], c[1:0], 4'h0});
         chk(16'({coma, comb}), 16'({c[1:0], c[1:0]}), "com");
         repeat (3)
         begin
            @(posedge clk);
            {oca, ocb, pao, pad, pbo, pbd} <= 6'($urandom);
            repeat (2) @(posedge clk);
            chk(16'({pina, pinaoe}), 16'({exp_pin(c[1:0], oca, pao), pad}),
                "pin a");
            chk(16'({pinb, pinboe}), 16'({exp_pin(c[1:0], ocb, pbo), pbd}),
                "pin b");
         end
      end
      print_verdict();
   end
endmodule

`default_nettype wire
